// ### rtl/dmp_datapath.sv
// top of the multiply/prefetch datapath: accumulators, operand registers, pointers
// assumes one instruction per issue pulse; memory read data valid in the issue cycle
// What this block does
// - mpy puts operand product into accumulator
// - mpyn puts negated product into accumulator
// - msc subtracts product from named accumulator
// - each prefetch channel may be skipped entirely
// - pointers post-modify by literal or register
// - write-back stores the other accumulator
// - operands w4,w5; pointers w8,w10
// - signed by signed integer multiply
// - mixed-sign integer multiplies give signed result
// - unsigned by unsigned integer multiply
// - immediate literal may replace second operand of msu and muu
// - nop changes no state
// - mac adds product to named accumulator
`timescale 1ns/100ps
module dmp_datapath #(
    parameter int W = dmp_pkg::WORD_W,
    parameter int A = dmp_pkg::ACC_W
) (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic           issue,
    input  wire logic [3:0]     opcode,
    input  wire logic           accSel,
    input  wire logic           xEn,
    input  wire logic [2:0]     xIncSel,
    input  wire logic [W-1:0]   xIncReg,
    input  wire logic           xDestB,
    input  wire logic           yEn,
    input  wire logic [2:0]     yIncSel,
    input  wire logic [W-1:0]   yIncReg,
    input  wire logic           yDestB,
    input  wire logic           wbEn,
    input  wire logic [W-1:0]   accum_writeback_dest,
    input  wire logic [W-1:0]   intOpA,
    input  wire logic [W-1:0]   intOpB,
    input  wire logic           useImm,
    input  wire logic [W-1:0]   immValue,
    input  wire logic [W-1:0]   xMemRdata,
    input  wire logic [W-1:0]   yMemRdata,
    output logic                xMemRd,
    output logic      [W-1:0]   xMemAddr,
    output logic                yMemRd,
    output logic      [W-1:0]   yMemAddr,
    output logic                wbWr,
    output logic      [W-1:0]   wbAddr,
    output logic      [W-1:0]   wbData,
    output logic      [2*W-1:0] intResult,
    output logic                intValid,
    output logic      [A-1:0]   accA_reg,
    output logic      [A-1:0]   accB_reg,
    output logic      [W-1:0]   multA_reg,
    output logic      [W-1:0]   multB_reg,
    output logic      [W-1:0]   xPtr,
    output logic      [W-1:0]   yPtr,
    output logic                busy
);
    // ========================================
    // decode
    logic         isDsp;
    logic         isInt;
    logic         dspCode;
    logic         intCode;
    logic         immOk;
    logic         wbOk;
    logic         signA;
    logic         signB;
    logic [W-1:0] mulA;
    logic [W-1:0] mulB;

    logic [W-1:0] xData;
    logic [W-1:0] yData;
    logic         xLoaded;
    logic         yLoaded;
    logic         xDestHeld;
    logic         yDestHeld;

    // unused codes fall to the default and act as a no-operation
    always_comb begin
        dspCode = 1'b0;
        intCode = 1'b0;
        immOk   = 1'b0;
        wbOk    = 1'b0;
        unique case (opcode)
            dmp_pkg::OP_MPY, dmp_pkg::OP_MPYN: begin
                dspCode = 1'b1;
            end
            dmp_pkg::OP_MAC, dmp_pkg::OP_MSC: begin
                dspCode = 1'b1;
                wbOk    = 1'b1;
            end
            dmp_pkg::OP_MSS, dmp_pkg::OP_MUS: begin
                intCode = 1'b1;
            end
            dmp_pkg::OP_MSU, dmp_pkg::OP_MUU: begin
                intCode = 1'b1;
                immOk   = 1'b1;
            end
            default: begin
                dspCode = 1'b0;
            end
        endcase
    end

    assign isDsp = issue && dspCode;
    assign isInt = issue && intCode;

    // ========================================
    // operand and sign selection
    always_comb begin
        signA = 1'b1;
        signB = 1'b1;
        mulA  = multA_reg;
        mulB  = multB_reg;
        // a prefetch lands in w4/w5 one edge late; bypass it so the very next
        // instruction already multiplies the fetched word
        if (xLoaded && !xDestHeld) mulA = xData;
        if (xLoaded && xDestHeld)  mulB = xData;
        if (yLoaded && !yDestHeld) mulA = yData;
        if (yLoaded && yDestHeld)  mulB = yData;
        if (isInt) begin
            mulA = intOpA;
            mulB = (useImm && immOk) ? immValue : intOpB;
            unique case (opcode)
                dmp_pkg::OP_MSS: begin
                    signA = 1'b1;
                    signB = 1'b1;
                end
                dmp_pkg::OP_MSU: begin
                    signA = 1'b1;
                    signB = 1'b0;
                end
                dmp_pkg::OP_MUS: begin
                    signA = 1'b0;
                    signB = 1'b1;
                end
                default: begin
                    signA = 1'b0;
                    signB = 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // multiplier: product lands one cycle after issue
    // the held opcode and select steer the accumulator when the product lands
    logic [2*W-1:0] product;
    logic [3:0]     opHeld;
    logic           accHeld;
    logic           dspPend;

    dmp_mult #(.W(W)) uMult (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .opA     (mulA),
        .opB     (mulB),
        .signA   (signA),
        .signB   (signB),
        .product (product)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opHeld   <= dmp_pkg::OP_NOP;
            accHeld  <= 1'b0;
            dspPend  <= 1'b0;
            intValid <= 1'b0;
        end else begin
            opHeld   <= opcode;
            accHeld  <= accSel;
            dspPend  <= isDsp;
            intValid <= isInt;
        end
    end

    assign intResult = product;
    assign busy      = dspPend;

    // ========================================
    // accumulator update
    // accCur is read at the landing edge, so back to back accumulations chain
    logic [A-1:0] prodExt;
    logic [A-1:0] accCur;
    logic [A-1:0] accNext;

    assign prodExt = {{(A-2*W){product[2*W-1]}}, product};
    assign accCur  = accHeld ? accB_reg : accA_reg;

    always_comb begin
        unique case (opHeld)
            dmp_pkg::OP_MPY:  accNext = prodExt;
            dmp_pkg::OP_MPYN: accNext = A'(~prodExt + 1'b1);
            dmp_pkg::OP_MAC:  accNext = A'(accCur + prodExt);
            dmp_pkg::OP_MSC:  accNext = A'(accCur - prodExt);
            default:          accNext = accCur;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accA_reg <= dmp_pkg::ACC_RST;
            accB_reg <= dmp_pkg::ACC_RST;
        end else if (dspPend) begin
            if (accHeld) begin
                accB_reg <= accNext;
            end else begin
                accA_reg <= accNext;
            end
        end
    end

    // ========================================
    // write-back of the other accumulator, taken at issue
    // an update still pending on that accumulator is bypassed, so a write-back
    // right behind a multiply stores the sum that multiply leaves
    logic [A-1:0] accOther;

    always_comb begin
        accOther = accSel ? accA_reg : accB_reg;
        if (dspPend && (accHeld != accSel)) begin
            accOther = accNext;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wbWr   <= 1'b0;
            wbAddr <= dmp_pkg::WORD_RST;
            wbData <= dmp_pkg::WORD_RST;
        end else begin
            wbWr <= isDsp && wbEn && wbOk;
            if (isDsp && wbEn) begin
                wbAddr <= accum_writeback_dest;
                // upper word of the 32-bit product field, as a stored result
                wbData <= accOther[2*W-1:W];
            end
        end
    end

    // ========================================
    // prefetch channels; only dsp operations may fetch
    // the multiply reads w4/w5 before the word fetched at the same edge lands

    dmp_prefetch #(.W(W)) uXfetch (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .issue    (isDsp),
        .enable   (xEn),
        .incSel   (xIncSel),
        .incReg   (xIncReg),
        .memRdata (xMemRdata),
        .memRd    (xMemRd),
        .memAddr  (xMemAddr),
        .ptr_reg  (xPtr),
        .data_reg (xData),
        .loaded   (xLoaded)
    );

    dmp_prefetch #(.W(W)) uYfetch (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .issue    (isDsp),
        .enable   (yEn),
        .incSel   (yIncSel),
        .incReg   (yIncReg),
        .memRdata (yMemRdata),
        .memRd    (yMemRd),
        .memAddr  (yMemAddr),
        .ptr_reg  (yPtr),
        .data_reg (yData),
        .loaded   (yLoaded)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xDestHeld <= 1'b0;
            yDestHeld <= 1'b1;
        end else if (isDsp) begin
            xDestHeld <= xDestB;
            yDestHeld <= yDestB;
        end
    end

    // ========================================
    // operand registers: prefetched values replace w4/w5 after the multiply used them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            multA_reg <= dmp_pkg::WORD_RST;
            multB_reg <= dmp_pkg::WORD_RST;
        end else begin
            // y written second so a clash resolves to the y value
            if (xLoaded && !xDestHeld) multA_reg <= xData;
            if (xLoaded && xDestHeld)  multB_reg <= xData;
            if (yLoaded && !yDestHeld) multA_reg <= yData;
            if (yLoaded && yDestHeld)  multB_reg <= yData;
        end
    end
endmodule : dmp_datapath

// ### rtl/dmp_pkg.sv
// package for the multiply/prefetch datapath: opcodes, widths, field encodings
// assumes nothing beyond a SystemVerilog-2012 compiler
package dmp_pkg;
    localparam int WORD_W = 16;
    localparam int ACC_W  = 40;
    localparam int LONG_W = 32;
    localparam int OP_W   = 4;
    localparam int INC_W  = 3;

    // ========================================
    // operation codes
    localparam logic [3:0] OP_NOP  = 4'h0;
    localparam logic [3:0] OP_MPY  = 4'h1;
    localparam logic [3:0] OP_MPYN = 4'h2;
    localparam logic [3:0] OP_MAC  = 4'h3;
    localparam logic [3:0] OP_MSC  = 4'h4;
    localparam logic [3:0] OP_MSS  = 4'h5;
    localparam logic [3:0] OP_MSU  = 4'h6;
    localparam logic [3:0] OP_MUS  = 4'h7;
    localparam logic [3:0] OP_MUU  = 4'h8;

    // ========================================
    // working-register indices used by the encoded form
    localparam logic [3:0] W_MULT_A = 4'h4;
    localparam logic [3:0] W_MULT_B = 4'h5;
    localparam logic [3:0] W_XPTR   = 4'h8;
    localparam logic [3:0] W_YPTR   = 4'hA;

    // ========================================
    // literal increment code: 0..6 map to -6,-4,-2,0,2,4,6 bytes; 7 = from register
    localparam logic [2:0] INC_REG    = 3'h7;
    localparam logic [2:0] INC_ZERO   = 3'h3;
    localparam int         INC_STEP   = 2;

    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage : dmp_pkg

// ### rtl/dmp_mult.sv
// 16x16 multiplier with per-operand sign control, registered 32-bit product
// assumes operands held stable by caller for the issuing cycle
`timescale 1ns/100ps
module dmp_mult #(
    parameter int W = 16
) (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic [W-1:0]   opA,
    input  wire logic [W-1:0]   opB,
    input  wire logic           signA,
    input  wire logic           signB,
    output logic      [2*W-1:0] product
);
    logic signed [W:0]     extA;
    logic signed [W:0]     extB;
    logic signed [2*W+1:0] full;

    // ========================================
    // one extension bit per operand covers all four sign modes
    assign extA = {signA & opA[W-1], opA};
    assign extB = {signB & opB[W-1], opB};
    assign full = extA * extB;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            product <= '0;
        end else begin
            product <= full[2*W-1:0];
        end
    end
endmodule : dmp_mult

// ### rtl/dmp_prefetch.sv
// one prefetch channel: read through pointer, post-modify pointer
// assumes the memory port answers combinationally in the same cycle
`timescale 1ns/100ps
module dmp_prefetch #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         issue,
    input  wire logic         enable,
    input  wire logic [2:0]   incSel,
    input  wire logic [W-1:0] incReg,
    input  wire logic [W-1:0] memRdata,
    output logic              memRd,
    output logic      [W-1:0] memAddr,
    output logic      [W-1:0] ptr_reg,
    output logic      [W-1:0] data_reg,
    output logic              loaded
);
    logic [W-1:0] step;
    logic         go;

    assign go      = issue & enable;
    assign memRd   = go;
    assign memAddr = ptr_reg;

    // literal codes step by 2 bytes around zero; last code takes the register
    always_comb begin
        if (incSel == dmp_pkg::INC_REG) begin
            step = incReg;
        end else begin
            step = W'((int'(incSel) - int'(dmp_pkg::INC_ZERO)) * dmp_pkg::INC_STEP);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg  <= dmp_pkg::WORD_RST;
            data_reg <= dmp_pkg::WORD_RST;
            loaded   <= 1'b0;
        end else begin
            loaded <= go;
            if (go) begin
                data_reg <= memRdata;
                ptr_reg  <= ptr_reg + step;
            end
        end
    end
endmodule : dmp_prefetch

// ### bench/dmp_data_mem.sv
// X or Y data memory read port for the multiply/prefetch datapath
// assumes a combinational answer in the cycle of the read strobe
`timescale 1ns/100ps
module dmp_data_mem #(
    parameter logic [15:0] KEY = 16'h0000
) (
    input  wire logic        rd,
    input  wire logic [15:0] addr,
    output logic      [15:0] rdata
);
    // ========================================
    // content is a keyed scramble of the address; each space has its own key
    // unselected port shows the inverse so stale data never passes for a read
    assign rdata = rd ? (addr ^ KEY) : ~(addr ^ KEY);
endmodule : dmp_data_mem

// ### bench/dmp_datapath_properties.sv
// timing and value checks on the ports of the multiply/prefetch datapath
// assumes the single mclk domain with rst_n asynchronous active low
`timescale 1ns/100ps
module dmp_datapath_properties #(
    parameter int W = 16,
    parameter int A = 40
) (
    input wire logic           mclk,
    input wire logic           rst_n,
    input wire logic           issue,
    input wire logic [3:0]     opcode,
    input wire logic           xEn,
    input wire logic [2:0]     xIncSel,
    input wire logic           wbEn,
    input wire logic [W-1:0]   accum_writeback_dest,
    input wire logic [W-1:0]   intOpA,
    input wire logic [W-1:0]   intOpB,
    input wire logic           useImm,
    input wire logic           xMemRd,
    input wire logic [W-1:0]   xMemAddr,
    input wire logic [W-1:0]   xPtr,
    input wire logic           wbWr,
    input wire logic [W-1:0]   wbAddr,
    input wire logic [2*W-1:0] intResult,
    input wire logic           intValid,
    input wire logic [A-1:0]   accA_reg,
    input wire logic [A-1:0]   accB_reg,
    input wire logic [W-1:0]   multA_reg
);
    // ========================================
    // helpers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic dspOp;
    logic intOp;
    assign dspOp = issue && opcode >= 4'h1 && opcode <= 4'h4;
    assign intOp = issue && opcode >= 4'h5 && opcode <= 4'h8;

    // ========================================
    // assertions
    chk_x_read_gate: assert property (xMemRd == (dspOp && xEn))
        else $error("x read strobe wrong");
    chk_x_addr_ptr: assert property (xMemRd |-> xMemAddr == xPtr)
        else $error("x address is not the pointer");
    chk_x_ptr_idle: assert property (!xMemRd |=> $stable(xPtr))
        else $error("x pointer moved without a read");
    chk_x_ptr_step: assert property (xMemRd && xIncSel != 3'h7 |=>
        xPtr == 16'($past(xPtr) + 2 * $past(xIncSel) - 6))
        else $error("x pointer step wrong");
    chk_int_valid: assert property (intOp |=> intValid)
        else $error("integer result not flagged");
    chk_int_quiet: assert property (!intOp |=> !intValid)
        else $error("spurious integer result");
    chk_ss_product: assert property (issue && opcode == 4'h5 |=>
        $signed(intResult) == $signed($past(intOpA)) * $signed($past(intOpB)))
        else $error("signed product wrong");
    chk_uu_product: assert property (issue && opcode == 4'h8 && !useImm |=>
        intResult == $past(intOpA) * $past(intOpB))
        else $error("unsigned product wrong");
    chk_wb_strobe: assert property (issue && opcode inside {4'h3, 4'h4} && wbEn |=>
        wbWr && wbAddr == $past(accum_writeback_dest))
        else $error("write-back missing");
    chk_wb_refused: assert property (issue && opcode <= 4'h2 |=> !wbWr)
        else $error("write-back not refused");
    chk_nop_still: assert property (issue && opcode == 4'h0 |=> ##1
        $stable(accA_reg) && $stable(accB_reg) && $stable(multA_reg))
        else $error("nop changed state");
endmodule : dmp_datapath_properties

bind dmp_datapath dmp_datapath_properties #(.W(W), .A(A)) chk_i (
    .mclk(mclk), .rst_n(rst_n), .issue(issue), .opcode(opcode), .xEn(xEn),
    .xIncSel(xIncSel), .wbEn(wbEn), .accum_writeback_dest(accum_writeback_dest),
    .intOpA(intOpA), .intOpB(intOpB), .useImm(useImm), .xMemRd(xMemRd),
    .xMemAddr(xMemAddr), .xPtr(xPtr), .wbWr(wbWr), .wbAddr(wbAddr),
    .intResult(intResult), .intValid(intValid), .accA_reg(accA_reg),
    .accB_reg(accB_reg), .multA_reg(multA_reg));

// ### bench/tb.sv
// self-checking bench for the multiply/prefetch datapath
// assumes dmp_pkg compiled first; X and Y memories are bench models
`timescale 1ns/100ps
module tb;
    logic mclk, rst_n, issue, accSel, xEn, xDestB, yEn, yDestB, wbEn, useImm;
    logic xMemRd, yMemRd, wbWr, intValid, busy;
    logic [3:0] opcode;
    logic [2:0] xIncSel, yIncSel;
    logic [15:0] xIncReg, yIncReg, accum_writeback_dest, intOpA, intOpB, immValue;
    logic [15:0] xMemRdata, yMemRdata, xMemAddr, yMemAddr, wbAddr, wbData;
    logic [15:0] multA_reg, multB_reg, xPtr, yPtr, ex, ey, ea, eb, bo;
    logic [31:0] intResult;
    logic [39:0] accA_reg, accB_reg, p;
    int errors, samples_checked;

    dmp_datapath uut (
        .mclk(mclk), .rst_n(rst_n), .issue(issue), .opcode(opcode), .accSel(accSel),
        .xEn(xEn), .xIncSel(xIncSel), .xIncReg(xIncReg), .xDestB(xDestB), .yEn(yEn),
        .yIncSel(yIncSel), .yIncReg(yIncReg), .yDestB(yDestB), .wbEn(wbEn),
        .accum_writeback_dest(accum_writeback_dest), .intOpA(intOpA), .intOpB(intOpB),
        .useImm(useImm), .immValue(immValue), .xMemRdata(xMemRdata),
        .yMemRdata(yMemRdata), .xMemRd(xMemRd), .xMemAddr(xMemAddr), .yMemRd(yMemRd),
        .yMemAddr(yMemAddr), .wbWr(wbWr), .wbAddr(wbAddr), .wbData(wbData),
        .intResult(intResult), .intValid(intValid), .accA_reg(accA_reg),
        .accB_reg(accB_reg), .multA_reg(multA_reg), .multB_reg(multB_reg), .xPtr(xPtr),
        .yPtr(yPtr), .busy(busy));
    dmp_data_mem #(.KEY(16'h5A3C)) xMem (.rd(xMemRd), .addr(xMemAddr), .rdata(xMemRdata));
    dmp_data_mem #(.KEY(16'hC3A5)) yMem (.rd(yMemRd), .addr(yMemAddr), .rdata(yMemRdata));

    // ========================================
    // helpers
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic run(input logic [3:0] o, input logic xe, input logic [2:0] xi,
                       input logic ye, input logic [2:0] yi, input logic acc, wb);
        @(posedge mclk);
        #1;
        {opcode, xEn, xIncSel, yEn, yIncSel, accSel, wbEn} = {o, xe, xi, ye, yi, acc, wb};
        issue = 1'b1;
        @(posedge mclk);
        #1;
        issue = 1'b0;
    endtask : run

    task automatic settle();
        @(posedge mclk);
        #1;
    endtask : settle

    function automatic logic [31:0] mul(input logic [15:0] a, b, input logic sa, sb);
        return $signed({sa & a[15], a}) * $signed({sb & b[15], b});
    endfunction : mul

    // ========================================
    // scenarios
    task automatic s_prefetch();
        for (int k = 0; k < 8; k++) begin
            ea = ex ^ 16'h5A3C;
            eb = ey ^ 16'hC3A5;
            run(4'h1, 1'b1, 3'(k), 1'b1, (k == 7) ? 3'h7 : 3'(6 - k), 1'b0, 1'b0);
            ex = ex + ((k == 7) ? xIncReg : 16'(2 * k - 6));
            ey = ey + ((k == 7) ? yIncReg : 16'(6 - 2 * k));
            chk(xPtr, ex);
            chk(yPtr, ey);
            settle();
            chk(multA_reg, ea);
            chk(multB_reg, eb);
        end
    endtask : s_prefetch

    task automatic s_accum();
        p = 40'($signed(mul(ea, eb, 1'b1, 1'b1)));
        run(4'h1, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
        chk(busy, 1'b1);
        settle();
        chk(accA_reg, p);
        run(4'h2, 1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        settle();
        chk(accB_reg, -p);
        run(4'h3, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b1);
        chk({wbWr, wbAddr, wbData}, {1'b1, accum_writeback_dest, 16'((-p) >> 16)});
        settle();
        chk(accA_reg, 2 * p);
        run(4'h4, 1'b0, 3'h0, 1'b1, 3'h5, 1'b1, 1'b1);
        chk({wbData, xPtr, yPtr}, {16'((2 * p) >> 16), ex, 16'(ey + 16'h0004)});
        settle();
        chk(accB_reg, -2 * p);
        eb = ey ^ 16'hC3A5;
        ey = ey + 16'h0004;
        chk({multA_reg, multB_reg}, {ea, eb});
    endtask : s_accum

    task automatic s_int();
        for (int k = 0; k < 8; k++) begin
            useImm = k[0];
            bo = (k[0] && k[2:1] inside {2'h1, 2'h3}) ? immValue : intOpB;
            run(4'(5 + k[2:1]), 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
            // signed/unsigned per opcode: 5 ss, 6 su, 7 us, 8 uu
            chk({intValid, intResult}, {1'b1, mul(intOpA, bo, k[2:1] <= 2'h1,
                k[2:1] inside {2'h0, 2'h2})});
        end
        useImm = 1'b0;
    endtask : s_int

    task automatic s_nop();
        // unused codes must behave exactly like the no-operation
        for (int i = 0; i < 2; i++) begin
            run((i == 1) ? 4'hF : 4'h0, 1'b1, 3'h6, 1'b1, 3'h6, 1'b1, 1'b1);
            chk({wbWr, intValid, busy, xPtr, yPtr}, {3'b000, ex, ey});
            settle();
            chk(accA_reg, 2 * p);
            chk(accB_reg, -2 * p);
            chk({multA_reg, multB_reg}, {ea, eb});
        end
    endtask : s_nop

    task automatic s_chain();
        logic [39:0] q;
        // back to back: the second instruction sees the fetched word and the
        // sum the first one leaves in the other accumulator
        q  = 40'($signed(mul(ea, eb, 1'b1, 1'b1)));
        ea = ex ^ 16'h5A3C;
        @(posedge mclk);
        #1;
        {opcode, xEn, xIncSel, yEn, accSel, wbEn} = {4'h1, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0};
        issue = 1'b1;
        @(posedge mclk);
        #1;
        {opcode, xEn, accSel, wbEn} = {4'h3, 1'b0, 1'b1, 1'b1};
        @(posedge mclk);
        #1;
        issue = 1'b0;
        chk({wbWr, wbData}, {1'b1, 16'(q >> 16)});
        settle();
        chk(accA_reg, q);
        chk(accB_reg, 40'($signed(mul(ea, eb, 1'b1, 1'b1))) - 2 * p);
    endtask : s_chain

    task automatic results();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // ========================================
    // clock, watchdog, main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #100000;
        errors++;
        results();
    end

    initial begin
        {issue, accSel, xEn, yEn, wbEn, useImm, opcode, xIncSel, yIncSel} = '0;
        {xDestB, yDestB, rst_n} = 3'b010;
        {xIncReg, yIncReg, accum_writeback_dest} = {16'h0010, 16'hFFF0, 16'h0ABC};
        {intOpA, intOpB, immValue} = {16'h8001, 16'hFFFE, 16'h7FF3};
        {ex, ey, ea, eb, p, errors, samples_checked} = '0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        s_prefetch();
        s_accum();
        s_int();
        s_nop();
        s_chain();
        results();
    end
endmodule : tb
